// >>> sps_pkg.sv
// Purpose: constants, types and helpers of the serial port block
// Assumes: one 25 MHz clock, AXI4-Lite register access with 32-bit data
// Notes: register words hold 8 data bits in the low byte
// What this block does
// - Slave with select high stays passive, all pins inputs, ignores data.
// - Slave select rising resets bit counter, keeps shifter contents, drops partial byte.
// - Slave with select low is active; MISO drives only if configured.
// - Master with select as output: plain output, no effect on engine.
// - Select input low in master mode clears master bit, becomes slave.
// - That demotion sets done flag, which may raise the interrupt.
// - Data changes on one clock edge and is sampled on the opposite.
// - Phase 0 samples on leading edge, phase 1 on trailing edge.
// - Polarity 1 idles clock high; polarity 0 idles it low.
// - Control bit 7 with done flag and global enable requests interrupt.
// - Control bit 6 enables the port; nothing happens while it is zero.
// - Control bit 5 set shifts least significant bit first.
// - Control bit 4 selects master when one, slave when zero.
// - Master clock divides by 4,16,64,128, or 2,8,32,64 doubled.
// - Done flag sets on byte end; clears by vector or status-then-data.
// - Collision flag sets on data write mid-transfer; status-then-data clears.
// - Status bits 5 to 1 always read zero.
// - Status bit 0 doubles master rate, shortest period two clocks.
// - Data write starts a transfer in master mode, only loads shifter as slave; data read returns the receive buffer.
// - Each transfer is eight bits; master clock stops, done flag sets.
// - Receive is double buffered; unread byte is overwritten by next.
// - Slave with select high tri-states MISO; shifting waits for select low.
package sps_pkg;
  // Register byte addresses
  localparam int SPS_AW = 8;
  localparam logic [7:0] SPS_ADDR_CTRL = 8'h2c;
  localparam logic [7:0] SPS_ADDR_STAT = 8'h30;
  localparam logic [7:0] SPS_ADDR_DATA = 8'h34;
  localparam logic [7:0] SPS_ADDR_PIN = 8'h38;
  // Control fields
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_LSB_FIRST = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_IDLE_LVL = 3;
  localparam int CTRL_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Status fields
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_RSV_HI = 5;
  localparam int STAT_RSV_LO = 1;
  localparam int STAT_DBL = 0;
  // Pin configuration fields
  localparam int PIN_MISO_DIR = 0;
  localparam int PIN_MOSI_DIR = 1;
  localparam int PIN_SCK_DIR = 2;
  localparam int PIN_SS_DIR = 3;
  localparam int PIN_SS_LEVEL = 4;
  localparam int PIN_GLOBAL_IE = 5;
  localparam logic [5:0] PIN_RESET = 6'h00;
  // Sixteen clock edges per byte, counted 0 to 15
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] FIRST_EDGE = 4'h0;
  // Longest master byte in clocks: sixteen slowest half periods plus start slack
  localparam logic [10:0] BYTE_MAX_CLKS = 11'h402;
  // Half clock periods in system clocks, indexed by {double, rate}
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SPS_REG_CTRL, SPS_REG_STAT, SPS_REG_DATA, SPS_REG_PIN,
    SPS_REG_NONE} sps_reg_t;
  typedef enum logic {SPS_IDLE, SPS_RUN} sps_eng_t;

  typedef struct packed {
    logic awvalid;
    logic [SPS_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [SPS_AW-1:0] araddr;
    logic rready;
  } sps_axi_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sps_axi_out_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } sps_pins_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } sps_pins_out_t;

  // Half period lookup for the master clock
  function automatic logic [6:0] sps_half_period(input logic [2:0] code);
    case (code)
      3'h0: sps_half_period = HALF_DIV4;
      3'h1: sps_half_period = HALF_DIV16;
      3'h2: sps_half_period = HALF_DIV64;
      3'h3: sps_half_period = HALF_DIV128;
      3'h4: sps_half_period = HALF_DIV2;
      3'h5: sps_half_period = HALF_DIV8;
      3'h6: sps_half_period = HALF_DIV32;
      default: sps_half_period = HALF_DIV64;
    endcase
  endfunction

  // Word address decode, low two address bits ignored
  function automatic sps_reg_t sps_decode(input logic [SPS_AW-1:0] a);
    logic [SPS_AW-1:0] w;
    w = {a[SPS_AW-1:2], 2'h0};
    if (w == SPS_ADDR_CTRL) sps_decode = SPS_REG_CTRL;
    else if (w == SPS_ADDR_STAT) sps_decode = SPS_REG_STAT;
    else if (w == SPS_ADDR_DATA) sps_decode = SPS_REG_DATA;
    else if (w == SPS_ADDR_PIN) sps_decode = SPS_REG_PIN;
    else sps_decode = SPS_REG_NONE;
  endfunction

  // Bit leaving the shifter next
  function automatic logic sps_out_bit(input logic [7:0] sh, input logic lsbf);
    sps_out_bit = lsbf ? sh[0] : sh[7];
  endfunction

  // Shift one bit out and one bit in
  function automatic logic [7:0] sps_shift_in(input logic [7:0] sh, input logic b,
      input logic lsbf);
    sps_shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction
endpackage

// >>> sps_rate_gen.sv
// Purpose: master clock half-period tick generator
// Assumes: run is held for the whole byte
// Notes: counter restarts whenever run drops, so each byte starts clean
`timescale 1ns/10ps
`default_nettype none
module sps_rate_gen import sps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic run,
  input wire logic [2:0] code,
  // Half-period pulse
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
  } sps_gen_state_t;

  sps_gen_state_t q, d;
  logic [6:0] half;

  // Tick on the last count of each half period
  always_comb begin
    half = sps_half_period(code);
    tick = run && (q.cnt == half - 7'h01);
    d = q;
    if (!run || tick) begin
      d.cnt = 7'h00;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// >>> sps_port.sv
// Purpose: byte-wide serial port, master or slave, with AXI4-Lite registers
// Assumes: pin inputs synchronous to clock except the slave clock path
// Notes: pins come as value plus output enable; the pad resolves the wire
`timescale 1ns/10ps
`default_nettype none
module sps_port import sps_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register bus
  input wire sps_axi_in_t axi_in,
  output sps_axi_out_t axi_out,
  // Serial pins
  input wire sps_pins_in_t pins_in,
  output sps_pins_out_t pins_out,
  // Interrupt request and vector taken
  output logic irq,
  input wire logic irq_ack
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic dbl;
    logic [5:0] pincfg;
    logic done_flag;
    logic write_collision_flag_flag;
    logic clear_armed;
    logic [7:0] rxbuf;
    logic [7:0] shreg;
    logic rx_bit;
    logic [3:0] edge_cnt;
    sps_eng_t eng;
    logic sck_lvl;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic mosi_s1;
    logic mosi_s2;
    logic ss_s1;
    logic ss_s2;
    logic ss_s3;
    logic aw_have;
    logic [SPS_AW-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wlane0;
    logic start;
    logic irq;
    sps_axi_out_t axo;
    sps_pins_out_t pins;
  } sps_state_t;

  sps_state_t q, d;
  logic tick;
  logic gen_run;
  sps_reg_t wsel;
  sps_reg_t rsel;
  logic en, mst, lsbf, clock_sample_phase, clock_idle_level;
  logic edge_ev, sample_edge, in_bit;

  // Master clock divider runs only while a master byte is in flight
  assign gen_run = (q.eng == SPS_RUN) && q.ctrl[CTRL_MASTER] && q.ctrl[CTRL_PORT_EN];

  sps_rate_gen u_rate (
    .clock(clock),
    .arst_n(arst_n),
    .run(gen_run),
    .code({q.dbl, q.ctrl[CTRL_RATE_HI], q.ctrl[CTRL_RATE_LO]}),
    .tick(tick)
  );

  // Whole next-state of the block
  always_comb begin
    d = q;
    d.start = 1'b0;
    wsel = sps_decode(q.awaddr);
    rsel = sps_decode(axi_in.araddr);
    en = 1'b0;
    mst = 1'b0;
    lsbf = 1'b0;
    clock_sample_phase = 1'b0;
    clock_idle_level = 1'b0;
    edge_ev = 1'b0;
    sample_edge = 1'b0;
    in_bit = 1'b0;

    // Pin synchronisers; first stages feed only the second
    d.sck_s1 = pins_in.sck;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.mosi_s1 = pins_in.mosi;
    d.mosi_s2 = q.mosi_s1;
    d.ss_s1 = pins_in.ss_n;
    d.ss_s2 = q.ss_s1;
    d.ss_s3 = q.ss_s2;

    // Vector taken clears the done flag; later sets still win
    if (irq_ack) begin
      d.done_flag = 1'b0;
    end

    // Write address and data channels, taken in either order
    if (axi_in.awvalid && q.axo.awready) begin
      d.aw_have = 1'b1;
      d.awaddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && q.axo.wready) begin
      d.w_have = 1'b1;
      d.wdata = axi_in.wdata[7:0];
      d.wlane0 = axi_in.wstrb[0];
    end
    if (q.axo.bvalid && axi_in.bready) begin
      d.axo.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (q.aw_have && q.w_have && !q.axo.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.axo.bvalid = 1'b1;
      d.axo.bresp = (wsel == SPS_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      // Data access completes a pending flag clear
      if (wsel == SPS_REG_DATA && q.clear_armed) begin
        d.done_flag = 1'b0;
        d.write_collision_flag_flag = 1'b0;
        d.clear_armed = 1'b0;
      end
      if (q.wlane0) begin
        case (wsel)
          SPS_REG_CTRL: d.ctrl = q.wdata;
          SPS_REG_STAT: d.dbl = q.wdata[STAT_DBL];
          SPS_REG_PIN: d.pincfg = q.wdata[5:0];
          SPS_REG_DATA: begin
            // Transmit side is single buffered: mid-byte writes are refused
            if (q.eng == SPS_RUN) begin
              d.write_collision_flag_flag = 1'b1;
            end else begin
              d.shreg = q.wdata;
              if (q.ctrl[CTRL_PORT_EN] && q.ctrl[CTRL_MASTER]) begin
                d.eng = SPS_RUN;
                d.edge_cnt = FIRST_EDGE;
                d.start = 1'b1;
              end
            end
          end
          default: d.axo.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Read channel; one read answered at a time
    if (q.axo.rvalid && axi_in.rready) begin
      d.axo.rvalid = 1'b0;
    end
    if (axi_in.arvalid && q.axo.arready) begin
      d.axo.rvalid = 1'b1;
      d.axo.rresp = RESP_OKAY;
      d.axo.rdata = 32'h0000_0000;
      case (rsel)
        SPS_REG_CTRL: d.axo.rdata[7:0] = q.ctrl;
        SPS_REG_STAT: begin
          d.axo.rdata[STAT_DONE] = q.done_flag;
          d.axo.rdata[STAT_WRITE_COLLISION_FLAG] = q.write_collision_flag_flag;
          d.axo.rdata[STAT_DBL] = q.dbl;
          if (q.done_flag || q.write_collision_flag_flag) begin
            d.clear_armed = 1'b1;
          end
        end
        SPS_REG_DATA: begin
          d.axo.rdata[7:0] = q.rxbuf;
          if (q.clear_armed) begin
            d.done_flag = 1'b0;
            d.write_collision_flag_flag = 1'b0;
            d.clear_armed = 1'b0;
          end
        end
        SPS_REG_PIN: d.axo.rdata[5:0] = q.pincfg;
        default: d.axo.rresp = RESP_SLVERR;
      endcase
    end

    en = d.ctrl[CTRL_PORT_EN];
    lsbf = d.ctrl[CTRL_LSB_FIRST];
    clock_sample_phase = d.ctrl[CTRL_PHASE];
    clock_idle_level = d.ctrl[CTRL_IDLE_LVL];

    // Select input pulled low while master: step down to slave
    if (en && d.ctrl[CTRL_MASTER] && !d.pincfg[PIN_SS_DIR] && !q.ss_s2) begin
      d.ctrl[CTRL_MASTER] = 1'b0;
      d.done_flag = 1'b1;
      d.eng = SPS_IDLE;
      d.edge_cnt = FIRST_EDGE;
    end
    mst = d.ctrl[CTRL_MASTER];

    // Slave with select high is held reset and passive
    if (!en || (!mst && q.ss_s2)) begin
      d.eng = SPS_IDLE;
      d.edge_cnt = FIRST_EDGE;
    end

    // One clock edge to process, from divider or synchronised input
    if (en && mst && q.eng == SPS_RUN && d.eng == SPS_RUN) begin
      edge_ev = tick;
      in_bit = pins_in.miso;
      if (tick) begin
        d.sck_lvl = ~q.sck_lvl;
      end
    end else if (en && !mst && !q.ss_s2) begin
      edge_ev = (q.sck_s2 != q.sck_s3);
      in_bit = q.mosi_s2;
    end

    // Sample on one edge, set up on the other
    if (edge_ev) begin
      d.eng = SPS_RUN;
      sample_edge = (~d.edge_cnt[0]) ^ clock_sample_phase;
      if (sample_edge) begin
        if (d.edge_cnt == LAST_EDGE) begin
          d.shreg = sps_shift_in(d.shreg, in_bit, lsbf);
        end else begin
          d.rx_bit = in_bit;
        end
      end else if (!(clock_sample_phase && d.edge_cnt == FIRST_EDGE)) begin
        d.shreg = sps_shift_in(d.shreg, q.rx_bit, lsbf);
      end
      if (d.edge_cnt == LAST_EDGE) begin
        // Eighth bit done; the old buffer is overwritten if unread
        d.rxbuf = d.shreg;
        d.done_flag = 1'b1;
        d.eng = SPS_IDLE;
        d.edge_cnt = FIRST_EDGE;
      end else begin
        d.edge_cnt = d.edge_cnt + 4'h1;
      end
    end

    // Clock parks at its idle level between bytes
    if (d.eng == SPS_IDLE || !mst) begin
      d.sck_lvl = clock_idle_level;
    end

    // Pin drivers, registered so every output comes from a flop
    d.pins.sck_o = d.sck_lvl;
    d.pins.sck_oe = en && mst && d.pincfg[PIN_SCK_DIR];
    d.pins.mosi_o = sps_out_bit(d.shreg, lsbf);
    d.pins.mosi_oe = en && mst && d.pincfg[PIN_MOSI_DIR];
    d.pins.miso_o = sps_out_bit(d.shreg, lsbf);
    d.pins.miso_oe = en && !mst && d.pincfg[PIN_MISO_DIR] && !q.ss_s2;
    d.pins.ss_n_o = d.pincfg[PIN_SS_LEVEL];
    d.pins.ss_n_oe = en && mst && d.pincfg[PIN_SS_DIR];
    d.irq = d.done_flag && d.ctrl[CTRL_IRQ_EN] && d.pincfg[PIN_GLOBAL_IE];

    // Ready terms for the next cycle
    d.axo.awready = !d.aw_have && !d.axo.bvalid;
    d.axo.wready = !d.w_have && !d.axo.bvalid;
    d.axo.arready = !d.axo.rvalid;
  end

  // Single state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign axi_out = q.axo;
  assign pins_out = q.pins;
  assign irq = q.irq;

  // Clocks a master byte has been running; a counter, as the bound is too long for a delay
  logic [10:0] byte_clks_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      byte_clks_q <= '0;
    end else if (q.eng == SPS_RUN && q.ctrl[CTRL_MASTER]) begin
      byte_clks_q <= byte_clks_q + 11'h001;
    end else begin
      byte_clks_q <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_stat_read;
    axi_in.arvalid && q.axo.arready && rsel == SPS_REG_STAT;
  endsequence

  sequence s_master_busy;
    q.eng == SPS_RUN && q.ctrl[CTRL_MASTER];
  endsequence

  sequence s_demote;
    q.ctrl[CTRL_PORT_EN] && q.ctrl[CTRL_MASTER] && !q.pincfg[PIN_SS_DIR] && !q.ss_s2;
  endsequence

  a_reserved_zero: assert property (s_stat_read |=>
    q.axo.rdata[STAT_RSV_HI:STAT_RSV_LO] == 5'h00 && q.axo.rdata[STAT_DONE] == $past(q.done_flag))
    else $error("status reserved bits or done bit wrong");

  a_master_byte: assert property (s_master_busy |-> byte_clks_q < BYTE_MAX_CLKS)
    else $error("master byte did not complete");

  a_demote_slave: assert property (s_demote |=> !q.ctrl[CTRL_MASTER] && q.done_flag)
    else $error("master not demoted on select low");

  a_demote_pins: assert property (s_demote |=> !q.pins.sck_oe && !q.pins.mosi_oe)
    else $error("pins still driven after demotion");

  a_slave_reset: assert property (q.ctrl[CTRL_PORT_EN] && !q.ctrl[CTRL_MASTER]
    && q.ss_s2 && !q.ss_s3 |=> q.edge_cnt == FIRST_EDGE && q.eng == SPS_IDLE)
    else $error("slave logic not reset on select rise");

  a_slave_quiet: assert property (!q.ctrl[CTRL_MASTER] && q.ss_s2 |=> !q.pins.miso_oe)
    else $error("miso driven with select high");

  a_disabled_idle: assert property (!q.ctrl[CTRL_PORT_EN] |-> q.eng == SPS_IDLE
    && !q.pins.sck_oe && !q.pins.mosi_oe && !q.pins.miso_oe)
    else $error("port active while disabled");

  a_write_collision_flag_busy: assert property (q.aw_have && q.w_have && !q.axo.bvalid && q.wlane0
    && wsel == SPS_REG_DATA && q.eng == SPS_RUN |=> q.write_collision_flag_flag)
    else $error("collision flag not set");

  a_irq_request: assert property (q.done_flag && q.ctrl[CTRL_IRQ_EN]
    && q.pincfg[PIN_GLOBAL_IE] && !irq_ack |=> irq)
    else $error("interrupt not raised");

  a_sck_idle: assert property (q.ctrl[CTRL_PORT_EN] && q.ctrl[CTRL_MASTER]
    && q.eng == SPS_IDLE && !q.start |-> q.pins.sck_o == q.ctrl[CTRL_IDLE_LVL])
    else $error("clock not at idle level");
endmodule
`default_nettype wire

// >>> sps_far_end.sv
// Purpose: far-end serial device, slave to our master or master to our slave
// Assumes: holds each link clock level six system clocks when it drives the link
// Notes: released lines show a changing pattern, never a held last bit
`timescale 1ns/10ps
`default_nettype none
module sps_far_end import sps_pkg::*; (
  // Clock
  input wire logic clock,
  // Pads of the port
  input wire sps_pins_out_t pins_out,
  output sps_pins_in_t pins_in,
  // Last byte taken in
  output logic [7:0] got
);
  logic [7:0] tx = 8'h00;
  logic [1:0] mode = 2'h0;
  logic lsbf = 1'b0;
  logic first = 1'b1;
  logic m_sck = 1'b0;
  logic m_ss_n = 1'b1;
  logic obit, act, din;
  // Wire levels from both ends' enables
  assign obit = lsbf ? tx[0] : tx[7];
  assign act = pins_out.sck_oe | ~m_ss_n;
  assign pins_in.sck = pins_out.sck_oe ? pins_out.sck_o : m_sck;
  assign pins_in.mosi = pins_out.mosi_oe ? pins_out.mosi_o : (m_ss_n ? ~obit : obit);
  assign pins_in.miso = pins_out.miso_oe ? pins_out.miso_o : (pins_out.sck_oe ? obit : ~obit);
  assign pins_in.ss_n = pins_out.ss_n_oe ? pins_out.ss_n_o : m_ss_n;
  assign din = pins_out.sck_oe ? pins_in.mosi : pins_in.miso;
  // Sample on one edge, set up on the other; phase 1 keeps its first bit
  always @(pins_in.sck) begin
    if (act) begin
      if ((pins_in.sck != mode[1]) != mode[0]) begin
        got = lsbf ? {din, got[7:1]} : {got[6:0], din};
      end else begin
        if (!(first && mode[0])) tx = lsbf ? tx >> 1 : tx << 1;
        first = 1'b0;
      end
    end
  end
  // Byte, mode and bit order for the next frame
  task automatic load(input logic [7:0] b, input logic [2:0] m);
    tx = b;
    mode = m[1:0];
    lsbf = m[2];
    first = 1'b1;
    m_sck <= m[1];
  endtask
  task automatic select(input logic lvl);
    @(posedge clock);
    m_ss_n <= lvl;
  endtask
  // Six clocks a level keeps the link clock under a quarter of ours
  task automatic drive(input int nbits);
    select(1'b0);
    for (int i = 0; i < 2 * nbits; i++) begin
      repeat (6) @(posedge clock);
      m_sck <= ~m_sck;
    end
    repeat (6) @(posedge clock);
    m_ss_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the serial port block
// Assumes: far-end model answers as slave or drives frames as master
// Notes: all bus traffic goes through the shared read and write tasks
`timescale 1ns/10ps
`default_nettype none
module tb_top import sps_pkg::*;;
  logic clock, arst_n, irq, irq_ack, sck_prev;
  sps_axi_in_t axi_in;
  sps_axi_out_t axi_out;
  sps_pins_in_t pins_in;
  sps_pins_out_t pins_out;
  logic [7:0] got, rd_v, exp_v;
  logic [1:0] rsp;
  logic [3:0] wr_strb = 4'hf;
  int mismatches, checks_done, since, half_seen, toggles, t;
  logic [7:0] half_exp [8] = '{8'h02, 8'h08, 8'h20, 8'h40, 8'h01, 8'h04, 8'h10, 8'h20};

  sps_port sps_port_inst (.clock(clock), .arst_n(arst_n), .axi_in(axi_in),
    .axi_out(axi_out), .pins_in(pins_in), .pins_out(pins_out), .irq(irq), .irq_ack(irq_ack));
  sps_far_end sps_far_end_inst (.clock(clock), .pins_out(pins_out), .pins_in(pins_in),
    .got(got));

  // 25 MHz system clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Clocks between link clock toggles
  always @(posedge clock) begin
    sck_prev <= pins_out.sck_o;
    if (pins_out.sck_o !== sck_prev) begin
      half_seen <= since;
      since <= 1;
      toggles <= toggles + 1;
    end else since <= since + 1;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    axi_in.awaddr <= a;
    axi_in.wdata <= {~d, ~d, ~d, d};
    axi_in.wstrb <= wr_strb;
    axi_in.awvalid <= 1'b1;
    axi_in.wvalid <= 1'b1;
    axi_in.bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (axi_out.awready === 1'b1) axi_in.awvalid <= 1'b0;
      if (axi_out.wready === 1'b1) axi_in.wvalid <= 1'b0;
    end while (axi_out.bvalid !== 1'b1 && n < 200);
    axi_in.bready <= 1'b0;
    rsp = axi_out.bresp;
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    axi_in.araddr <= a;
    axi_in.arvalid <= 1'b1;
    axi_in.rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (axi_out.arready === 1'b1) axi_in.arvalid <= 1'b0;
    end while (axi_out.rvalid !== 1'b1 && n < 200);
    axi_in.rready <= 1'b0;
    rd_v = axi_out.rdata[7:0];
    rsp = axi_out.rresp;
    if (n >= 200) begin
      mismatches++;
      print_verdict();
    end
  endtask

  // Poll status until the byte is done
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(SPS_ADDR_STAT);
      n++;
    end while (rd_v[STAT_DONE] !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      print_verdict();
    end
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    irq_ack = 1'b0;
    axi_in = '0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    rd(SPS_ADDR_CTRL);
    check("ctrl reset", rd_v, 8'h00);
    // Low byte lane off: write ignored but answered OKAY
    wr_strb = 4'he;
    wr(SPS_ADDR_CTRL, 8'h5a);
    wr_strb = 4'hf;
    check("strobe off", {rsp, 6'h00}, {RESP_OKAY, 6'h00});
    rd(SPS_ADDR_CTRL + 8'h02);
    check("ctrl kept", rd_v, 8'h00);
    wr(SPS_ADDR_STAT, 8'hff);
    rd(SPS_ADDR_STAT);
    check("status bits", rd_v, 8'h01);
    rd(8'h3c);
    check("unmapped", {rsp, rd_v[5:0]}, {RESP_SLVERR, 6'h00});
    // Master: every rate code, mode and order, with a colliding write
    wr(SPS_ADDR_PIN, 8'h0e);
    for (int i = 0; i < 8; i++) begin
      exp_v = 8'hc3 + 8'(i);
      wr(SPS_ADDR_STAT, {7'h0, i[2]});
      wr(SPS_ADDR_CTRL, {2'b01, i[2], 1'b1, i[1:0], i[1:0]});
      sps_far_end_inst.load(exp_v, 3'(i));
      check("sck idle", {7'h0, pins_out.sck_o}, {7'h0, i[1]});
      check("ss output", {6'h0, pins_out.ss_n_oe, pins_out.ss_n_o}, 8'h02);
      wr(SPS_ADDR_DATA, 8'h5a ^ 8'(i));
      wr(SPS_ADDR_DATA, 8'hff);
      wait_done();
      check("status", rd_v, {2'b11, 5'h0, i[2]});
      check("rate", 8'(half_seen), half_exp[i]);
      rd(SPS_ADDR_DATA);
      check("rx byte", rd_v, exp_v);
      check("tx byte", got, 8'h5a ^ 8'(i));
      rd(SPS_ADDR_STAT);
      check("flags clear", rd_v, {7'h0, i[2]});
    end
    // Disabled port stays still
    wr(SPS_ADDR_STAT, 8'h00);
    wr(SPS_ADDR_CTRL, 8'h10);
    // Let the idle-level change of that write be counted first
    @(posedge clock);
    t = toggles;
    wr(SPS_ADDR_DATA, 8'h81);
    repeat (40) @(posedge clock);
    check("no toggles", 8'(toggles - t), 8'h00);
    rd(SPS_ADDR_STAT);
    check("no done", rd_v, 8'h00);
    // Select input pulled low demotes the master
    wr(SPS_ADDR_PIN, 8'h26);
    wr(SPS_ADDR_CTRL, 8'hd0);
    rd(SPS_ADDR_CTRL);
    check("master held", rd_v, 8'hd0);
    sps_far_end_inst.select(1'b0);
    repeat (8) @(posedge clock);
    check("demoted pins", {6'h0, pins_out.sck_oe, pins_out.mosi_oe}, 8'h00);
    check("irq", {7'h0, irq}, 8'h01);
    rd(SPS_ADDR_CTRL);
    check("demoted ctrl", rd_v, 8'hc0);
    irq_ack <= 1'b1;
    @(posedge clock);
    irq_ack <= 1'b0;
    sps_far_end_inst.select(1'b1);
    repeat (3) @(posedge clock);
    check("irq cleared", {7'h0, irq}, 8'h00);
    wr(SPS_ADDR_CTRL, 8'hd0);
    rd(SPS_ADDR_CTRL);
    check("master again", rd_v, 8'hd0);
    // Slave: select gating, a cut-short frame, then a whole one
    wr(SPS_ADDR_CTRL, 8'h6c);
    wr(SPS_ADDR_PIN, 8'h01);
    wr(SPS_ADDR_DATA, 8'h96);
    sps_far_end_inst.load(8'h00, 3'h7);
    check("miso idle", {7'h0, pins_out.miso_oe}, 8'h00);
    sps_far_end_inst.select(1'b0);
    repeat (6) @(posedge clock);
    check("miso on", {7'h0, pins_out.miso_oe}, 8'h01);
    sps_far_end_inst.select(1'b1);
    sps_far_end_inst.drive(3);
    rd(SPS_ADDR_STAT);
    check("cut frame", rd_v, 8'h00);
    sps_far_end_inst.load(8'h3b, 3'h7);
    sps_far_end_inst.drive(8);
    wait_done();
    rd(SPS_ADDR_DATA);
    check("slave rx", rd_v, 8'h3b);
    print_verdict();
  end
endmodule
`default_nettype wire
